// ==== common/ctk_regs.svh ====
// constants of the coupler tune and keying control: timing, thresholds, timer slots
// assumes a single 250 MHz clock; power samples arrive in 0.1 W steps
`ifndef CTK_REGS_SVH
`define CTK_REGS_SVH

// ----------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------
`define CTK_CLK_HZ        64'd250000000
`define CTK_MS_PER_S      64'd1000
`define CTK_MS2CYC(ms)    ((((ms) * `CTK_CLK_HZ) / `CTK_MS_PER_S))
`define CTK_T_KPV_MS      64'd75
`define CTK_T_FAULT_MS    64'd750
`define CTK_T_MATCH_MS    64'd1000
`define CTK_T_SEQ_MS      64'd25000
`define CTK_T_BLINK_MS    64'd500
`define CTK_CNT_W         34

// ----------------------------------------------------------------
// power thresholds, 0.1 W per step
// ----------------------------------------------------------------
`define CTK_THR_5W        16'h0032
`define CTK_THR_15W       16'h0096
`define CTK_VSWR2_MUL     20'h00009

// ----------------------------------------------------------------
// timer slots
// ----------------------------------------------------------------
`define CTK_TM_KPV        0
`define CTK_TM_MATCH      1
`define CTK_TM_FAULT      2
`define CTK_TM_SEQ        3
`define CTK_TM_BLINK      4
`define CTK_TM_N          5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTK_OE_OFF        1'b1
`define CTK_POR_RST       1'b1

`endif

// ==== common/ctk_pkg.sv ====
// types shared by the coupler tune and keying control
// assumes ctk_regs.svh supplies the numeric constants
package ctk_pkg;

    typedef enum logic [1:0] {
        CTK_HOMING,
        CTK_HOMED,
        CTK_TUNING,
        CTK_TUNED
    } ctk_seq_e;

    typedef struct packed {
        logic rechannel;
        logic key;
        logic elements_home;
        logic phase_inductive;
    } ctk_pins_s;

    typedef struct packed {
        logic tune_req;
        logic key_en_o;
        logic key_en_oe_n;
        logic key_en_sink;
        logic keyline_sink;
        logic status_o;
        logic status_oe_n;
        logic inductor_max;
        logic tuned;
        logic fault;
    } ctk_out_s;

endpackage

// ==== rtl/ctk_coupler_ctrl.sv ====
// coupler tune request, key permit, key hold, fault and inductor forcing logic
// assumes pins arrive asynchronous, power samples come from an adc on CLK
`timescale 1ns/100ps
`include "ctk_regs.svh"

module ctk_coupler_ctrl
    import ctk_pkg::*;
#(
    parameter int unsigned     CW          = `CTK_CNT_W,
    parameter logic [CW-1:0]   P_KPV_CYC   = CW'(`CTK_MS2CYC(`CTK_T_KPV_MS)),
    parameter logic [CW-1:0]   P_MATCH_CYC = CW'(`CTK_MS2CYC(`CTK_T_MATCH_MS)),
    parameter logic [CW-1:0]   P_FAULT_CYC = CW'(`CTK_MS2CYC(`CTK_T_FAULT_MS)),
    parameter logic [CW-1:0]   P_SEQ_CYC   = CW'(`CTK_MS2CYC(`CTK_T_SEQ_MS)),
    parameter logic [CW-1:0]   P_BLINK_CYC = CW'(`CTK_MS2CYC(`CTK_T_BLINK_MS))
) (
    // clock and reset
    input  wire logic          CLK,
    input  wire logic          RST_N,
    // discrete pins from transmitter and tuning elements
    input  wire logic          RECHANNEL,
    input  wire logic          KEY,
    input  wire logic          ELEMENTS_HOME,
    input  wire logic          PHASE_INDUCTIVE,
    // detected power samples and threshold choice
    input  wire logic [15:0]   FWD_PWR,
    input  wire logic [15:0]   RFL_PWR,
    input  wire logic          THR_SEL,
    // transmitter control lines
    output logic               TUNE_REQ,
    output logic               KEY_EN_O,
    output logic               KEY_EN_OE_N,
    output logic               KEY_EN_SINK,
    output logic               KEYLINE_SINK,
    // indicator line
    output logic               STATUS_O,
    output logic               STATUS_OE_N,
    // servo forcing and status
    output logic               INDUCTOR_MAX,
    output logic               TUNED,
    output logic               FAULT
);

    localparam int TM_N = `CTK_TM_N;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0]      pin_raw;
    logic [3:0]      sync1_reg;
    logic [3:0]      sync2_reg;
    ctk_pins_s       pins;

    assign pin_raw = {RECHANNEL, KEY, ELEMENTS_HOME, PHASE_INDUCTIVE};

    for (genvar g = 0; g < 4; g++) begin : g_sync
        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                sync1_reg[g] <= 1'b0;
                sync2_reg[g] <= 1'b0;
            end else begin
                sync1_reg[g] <= pin_raw[g];
                sync2_reg[g] <= sync1_reg[g];
            end
        end
    end

    assign pins = ctk_pins_s'(sync2_reg);

    // ----------------------------------------------------------------
    // restart: rechannel level or one cycle after power-on
    // ----------------------------------------------------------------
    logic            por_reg;
    logic            restart;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            por_reg <= `CTK_POR_RST;
        end else begin
            por_reg <= 1'b0;
        end
    end

    assign restart = pins.rechannel | por_reg;

    // ----------------------------------------------------------------
    // power detection
    // ----------------------------------------------------------------
    logic [15:0]     fwd_thr;
    logic [19:0]     rfl_x9;
    logic            fwd_seen;
    logic            match_good;
    logic            kpv;

    // match_good means reflected power is below one ninth of forward
    assign fwd_thr    = THR_SEL ? `CTK_THR_15W : `CTK_THR_5W;
    assign fwd_seen   = FWD_PWR > fwd_thr;
    assign rfl_x9     = 20'(RFL_PWR) * `CTK_VSWR2_MUL;
    assign match_good = rfl_x9 < 20'(FWD_PWR);

    // ----------------------------------------------------------------
    // delay timers, one counter per slot
    // ----------------------------------------------------------------
    ctk_seq_e        seq_reg;
    ctk_seq_e        seq_next;
    logic            fault_reg;
    logic            fault_next;
    logic            fault_in;
    logic [CW-1:0]   cnt_reg  [TM_N];
    logic [CW-1:0]   cnt_next [TM_N];
    logic [CW-1:0]   lim      [TM_N];
    logic [TM_N-1:0] run;
    logic [TM_N-1:0] wrap_en;
    logic [TM_N-1:0] done;
    logic            homing_or_tuning;

    // counts are derived from the clock rate, shortened by parameter in simulation
    assign lim[`CTK_TM_KPV]   = P_KPV_CYC;
    assign lim[`CTK_TM_MATCH] = P_MATCH_CYC;
    assign lim[`CTK_TM_FAULT] = P_FAULT_CYC;
    assign lim[`CTK_TM_SEQ]   = P_SEQ_CYC;
    assign lim[`CTK_TM_BLINK] = CW'(P_BLINK_CYC - 1'b1);

    assign homing_or_tuning = (seq_reg == CTK_HOMING) || (seq_reg == CTK_TUNING);
    assign fault_in = done[`CTK_TM_SEQ] | (kpv & ~match_good);

    assign run[`CTK_TM_KPV]   = fwd_seen;
    assign run[`CTK_TM_MATCH] = match_good & kpv & (seq_reg == CTK_TUNING);
    assign run[`CTK_TM_FAULT] = fault_in;
    assign run[`CTK_TM_SEQ]   = homing_or_tuning;
    assign run[`CTK_TM_BLINK] = fault_reg;
    assign wrap_en = TM_N'(1) << `CTK_TM_BLINK;

    for (genvar t = 0; t < TM_N; t++) begin : g_tmr
        assign done[t] = cnt_reg[t] == lim[t];
        // restart clears every timer so no stale delay survives a rechannel
        assign cnt_next[t] = (restart || !run[t]) ? '0 :
                             done[t] ? (wrap_en[t] ? '0 : cnt_reg[t]) :
                             CW'(cnt_reg[t] + 1'b1);
        always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
                cnt_reg[t] <= '0;
            end else begin
                cnt_reg[t] <= cnt_next[t];
            end
        end
    end

    // delayed forward power only counts while the key is down
    assign kpv = done[`CTK_TM_KPV] & pins.key;

    // ----------------------------------------------------------------
    // sequence state
    // ----------------------------------------------------------------
    always_comb begin
        seq_next = seq_reg;
        unique case (seq_reg)
            CTK_HOMING: begin
                if (pins.elements_home) begin
                    seq_next = CTK_HOMED;
                end
            end
            CTK_HOMED: begin
                if (pins.elements_home && kpv) begin
                    seq_next = CTK_TUNING;
                end
            end
            CTK_TUNING: begin
                if (done[`CTK_TM_MATCH]) begin
                    seq_next = CTK_TUNED;
                end
            end
            CTK_TUNED: begin
                seq_next = CTK_TUNED;
            end
        endcase
        if (restart) begin
            seq_next = CTK_HOMING;
        end
    end

    // ----------------------------------------------------------------
    // fault latch, key hold latch and blink phase
    // ----------------------------------------------------------------
    logic            fault_set;
    logic            hold_reg;
    logic            hold_next;
    logic            blink_reg;
    logic            blink_next;
    logic            tuned_now;

    assign tuned_now  = seq_reg == CTK_TUNED;
    assign fault_set  = done[`CTK_TM_FAULT];
    // set wins over restart so a fault landing on a one-cycle restart is not lost
    assign fault_next = fault_set | (fault_reg & ~restart);
    assign hold_next  = (hold_reg | pins.key) & ~tuned_now & ~fault_reg & ~restart;
    // indicator comes on at once when the fault latches, then toggles each half second
    assign blink_next = fault_reg ? (blink_reg ^ done[`CTK_TM_BLINK]) : 1'b1;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            seq_reg   <= CTK_HOMING;
            fault_reg <= 1'b0;
            hold_reg  <= 1'b0;
            blink_reg <= 1'b1;
        end else begin
            seq_reg   <= seq_next;
            fault_reg <= fault_next;
            hold_reg  <= hold_next;
            blink_reg <= blink_next;
        end
    end

    // ----------------------------------------------------------------
    // output registers
    // ----------------------------------------------------------------
    ctk_out_s        out_reg;
    ctk_out_s        out_next;
    logic            permit;
    logic            ind_drive;

    assign permit    = ~fault_reg & (seq_reg != CTK_HOMING);
    assign ind_drive = hold_reg | fault_reg;

    always_comb begin
        out_next.tune_req     = ((seq_reg == CTK_TUNING) ||
                                 (pins.key && seq_reg == CTK_HOMED)) && !tuned_now;
        out_next.key_en_o     = permit;
        out_next.key_en_oe_n  = ~permit;
        out_next.key_en_sink  = permit;
        out_next.keyline_sink = hold_reg;
        out_next.status_o     = fault_reg ? blink_reg : 1'b1;
        out_next.status_oe_n  = ~ind_drive;
        // the four forcing conditions; inductive phase ends the forcing
        out_next.inductor_max = kpv && !match_good && (seq_reg == CTK_TUNING) &&
                                !pins.phase_inductive;
        out_next.tuned        = tuned_now;
        out_next.fault        = fault_reg;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            out_reg             <= '0;
            out_reg.key_en_oe_n <= `CTK_OE_OFF;
            out_reg.status_oe_n <= `CTK_OE_OFF;
        end else begin
            out_reg <= out_next;
        end
    end

    assign TUNE_REQ     = out_reg.tune_req;
    assign KEY_EN_O     = out_reg.key_en_o;
    assign KEY_EN_OE_N  = out_reg.key_en_oe_n;
    assign KEY_EN_SINK  = out_reg.key_en_sink;
    assign KEYLINE_SINK = out_reg.keyline_sink;
    assign STATUS_O     = out_reg.status_o;
    assign STATUS_OE_N  = out_reg.status_oe_n;
    assign INDUCTOR_MAX = out_reg.inductor_max;
    assign TUNED        = out_reg.tuned;
    assign FAULT        = out_reg.fault;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_tune_req_on: assert property (@(posedge CLK) disable iff (!RST_N)
        (seq_reg == CTK_TUNING) |=> TUNE_REQ)
        else $error("tune request missing while tuning");

    chk_tune_req_off: assert property (@(posedge CLK) disable iff (!RST_N)
        tuned_now |=> !TUNE_REQ)
        else $error("tune request still up after match");

    chk_permit_off: assert property (@(posedge CLK) disable iff (!RST_N)
        (fault_reg || seq_reg == CTK_HOMING) |=> (!KEY_EN_SINK && KEY_EN_OE_N))
        else $error("permit given while faulted or homing");

    chk_permit_float: assert property (@(posedge CLK) disable iff (!RST_N)
        KEY_EN_OE_N |-> (!KEY_EN_SINK && !KEY_EN_O))
        else $error("permit forms disagree");

    chk_hold_set: assert property (@(posedge CLK) disable iff (!RST_N)
        (pins.key && !tuned_now && !fault_reg && !restart) |=> hold_reg ##1 KEYLINE_SINK)
        else $error("key hold not latched");

    chk_hold_free: assert property (@(posedge CLK) disable iff (!RST_N)
        (hold_reg && (tuned_now || fault_reg || restart)) |=> !hold_reg)
        else $error("key hold not released");

    chk_match_delay: assert property (@(posedge CLK) disable iff (!RST_N)
        $rose(tuned_now) |-> $past(cnt_reg[`CTK_TM_MATCH]) == P_MATCH_CYC)
        else $error("matched state without full delay");

    chk_status_hold: assert property (@(posedge CLK) disable iff (!RST_N)
        (hold_reg && !fault_reg) |=> (STATUS_O && !STATUS_OE_N))
        else $error("indicator not steady while key held");

    chk_fault_clear: assert property (@(posedge CLK) disable iff (!RST_N)
        (restart && !fault_set) |=> !fault_reg)
        else $error("fault survived restart");

    chk_seq_timer_clr: assert property (@(posedge CLK) disable iff (!RST_N)
        (!homing_or_tuning || restart) |=> (cnt_reg[`CTK_TM_SEQ] == '0))
        else $error("sequence timer not cleared");

    chk_indmax_off: assert property (@(posedge CLK) disable iff (!RST_N)
        pins.phase_inductive |=> !INDUCTOR_MAX)
        else $error("inductor forcing with inductive phase");

    chk_restart_home: assert property (@(posedge CLK) disable iff (!RST_N)
        restart |=> (seq_reg == CTK_HOMING) ##1 KEY_EN_OE_N)
        else $error("restart did not enter homing");

endmodule

// ==== dv/ctk_tx_model.sv ====
// transmitter model facing the coupler over discrete control lines
// assumes the bench sets carrier levels in 0.1 W steps on the same clock
`timescale 1ns/100ps
module ctk_tx_model (
    // clock
    input  wire logic        clk,
    // operator and bench controls
    input  wire logic        op_key,
    input  wire logic [15:0] fwd_lvl,
    input  wire logic [15:0] rfl_lvl,
    // lines from the coupler
    input  wire logic        tune_req,
    input  wire logic        key_en_o,
    input  wire logic        key_en_oe_n,
    input  wire logic        key_en_sink,
    input  wire logic        keyline_sink,
    // lines to the coupler
    output logic             key,
    output logic [15:0]      fwd_pwr,
    output logic [15:0]      rfl_pwr,
    output logic             carrier_cw
);
    logic permit;
    logic radiating;

    // a floating high drive reads as no permit, the input has a pull-down
    assign permit     = (!key_en_oe_n && key_en_o) || key_en_sink;
    // a held keyline keys the set just as the operator does
    assign key        = op_key || keyline_sink;
    assign radiating  = permit && key;
    assign carrier_cw = radiating && tune_req;

    initial begin
        fwd_pwr = 16'h0000;
        rfl_pwr = 16'h0000;
    end

    // detector reads zero from the clock edge after the carrier stops
    always @(posedge clk) begin
        fwd_pwr <= radiating ? fwd_lvl : 16'h0000;
        rfl_pwr <= radiating ? rfl_lvl : 16'h0000;
    end
endmodule

// ==== dv/testbench.sv ====
// self-checking bench of the coupler tune and keying control
// assumes the transmitter model and shortened delay parameters
`timescale 1ns/100ps
module testbench;
    import ctk_pkg::*;
    // ----------------------------------------
    // settings and signals
    // ----------------------------------------
    localparam int KPV = 20, MATCH = 40, FLT = 30, SEQ = 200, BLINK = 8, LIMIT = 6000;
    localparam int B_TREQ = 9, B_KEO = 8, B_KOE = 7, B_KSNK = 6, B_KLS = 5;
    localparam int B_ST = 4, B_STOE = 3, B_IND = 2, B_TUNED = 1, B_FLT = 0;
    logic        CLK, RST_N, RECHANNEL, ELEMENTS_HOME, PHASE_INDUCTIVE, THR_SEL;
    logic        op_key, KEY, carrier_cw;
    logic [15:0] fwd_lvl, rfl_lvl, FWD_PWR, RFL_PWR;
    logic        TUNE_REQ, KEY_EN_O, KEY_EN_OE_N, KEY_EN_SINK, KEYLINE_SINK;
    logic        STATUS_O, STATUS_OE_N, INDUCTOR_MAX, TUNED, FAULT;
    ctk_out_s    outs;
    logic [9:0]  ov;
    int          n_fail, tests_run, cyc;

    assign outs = {TUNE_REQ, KEY_EN_O, KEY_EN_OE_N, KEY_EN_SINK, KEYLINE_SINK,
                   STATUS_O, STATUS_OE_N, INDUCTOR_MAX, TUNED, FAULT};
    assign ov   = outs;

    ctk_coupler_ctrl #(.P_KPV_CYC(34'(KPV)), .P_MATCH_CYC(34'(MATCH)), .P_FAULT_CYC(34'(FLT)),
                       .P_SEQ_CYC(34'(SEQ)), .P_BLINK_CYC(34'(BLINK))) i_dut (
        .CLK(CLK), .RST_N(RST_N), .RECHANNEL(RECHANNEL), .KEY(KEY),
        .ELEMENTS_HOME(ELEMENTS_HOME), .PHASE_INDUCTIVE(PHASE_INDUCTIVE),
        .FWD_PWR(FWD_PWR), .RFL_PWR(RFL_PWR), .THR_SEL(THR_SEL),
        .TUNE_REQ(TUNE_REQ), .KEY_EN_O(KEY_EN_O), .KEY_EN_OE_N(KEY_EN_OE_N),
        .KEY_EN_SINK(KEY_EN_SINK), .KEYLINE_SINK(KEYLINE_SINK), .STATUS_O(STATUS_O),
        .STATUS_OE_N(STATUS_OE_N), .INDUCTOR_MAX(INDUCTOR_MAX), .TUNED(TUNED),
        .FAULT(FAULT));

    ctk_tx_model i_tx (
        .clk(CLK), .op_key(op_key), .fwd_lvl(fwd_lvl), .rfl_lvl(rfl_lvl),
        .tune_req(TUNE_REQ), .key_en_o(KEY_EN_O), .key_en_oe_n(KEY_EN_OE_N),
        .key_en_sink(KEY_EN_SINK), .keyline_sink(KEYLINE_SINK), .key(KEY),
        .fwd_pwr(FWD_PWR), .rfl_pwr(RFL_PWR), .carrier_cw(carrier_cw));

    always #2 CLK = ~CLK;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // a hang ends the run through the same report
    always @(posedge CLK) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_fail++;
            $display("BAD %0t run hung", $time);
            give_verdict();
        end
    end

    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi, input string what);
        tests_run++;
        if (got < lo || got > hi) begin
            n_fail++;
            $display("BAD %0t %s took %0d cycles", $time, what, got);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(negedge CLK);
    endtask

    task automatic wait_bit(input int b, input logic v, input int lim, output int n);
        n = 0;
        while (ov[b] !== v && n < lim) begin
            @(negedge CLK);
            n++;
        end
    endtask

    task automatic expect_within(input int b, input logic v, input int lim, input string what);
        int n;
        wait_bit(b, v, lim, n);
        chk(ov[b], v, what);
    endtask

    // elements are kept away from origin so homing lasts
    task automatic restart;
        ELEMENTS_HOME = 1'b0;
        RECHANNEL = 1'b1;
        cycles(4);
        RECHANNEL = 1'b0;
        cycles(4);
        chk({ov[B_KOE], ov[B_KSNK], ov[B_KLS], ov[B_TUNED], ov[B_FLT]}, 10'h010,
            "restart state");
    endtask

    task automatic home;
        ELEMENTS_HOME = 1'b1;
        expect_within(B_KSNK, 1'b1, 8, "homed sink permit");
        chk({ov[B_KEO], ov[B_KOE], ov[B_STOE]}, 10'h005, "homed drive permit");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        cycles(3);
        chk(ov, 10'h088, "reset values");
        cycles(3);
        RST_N = 1'b1;
        cycles(5);
        chk({ov[B_KOE], ov[B_KSNK]}, 10'h002, "power-on homing");
    endtask

    task automatic t_tune;
        int t0;
        restart();
        home();
        fwd_lvl = 16'h0033;
        rfl_lvl = 16'h0005;
        op_key = 1'b1;
        expect_within(B_TREQ, 1'b1, 5, "request on key at origin");
        chk(carrier_cw, 1'b1, "plain carrier while requested");
        t0 = cyc;
        expect_within(B_KLS, 1'b1, 3, "key hold set");
        cycles(4);
        op_key = 1'b0;
        cycles(10);
        chk({ov[B_KLS], ov[B_ST], ov[B_STOE]}, 10'h006, "hold past release");
        expect_within(B_TUNED, 1'b1, KPV + MATCH, "tuned reached");
        chk_rng(cyc - t0, KPV + MATCH - 4, KPV + MATCH + 6, "tune delay");
        expect_within(B_TREQ, 1'b0, 3, "request dropped on match");
        expect_within(B_KLS, 1'b0, 3, "hold freed on match");
        expect_within(B_STOE, 1'b1, 3, "indicator undriven");
        op_key = 1'b1;
        cycles(6);
        chk(ov[B_KLS], 1'b0, "no hold while tuned");
        op_key = 1'b0;
    endtask

    task automatic t_fault;
        int t0;
        restart();
        home();
        PHASE_INDUCTIVE = 1'b0;
        rfl_lvl = 16'h0014;
        op_key = 1'b1;
        expect_within(B_IND, 1'b1, KPV + 10, "inductor forced");
        t0 = cyc;
        PHASE_INDUCTIVE = 1'b1;
        expect_within(B_IND, 1'b0, 5, "forcing drops on inductive");
        expect_within(B_FLT, 1'b1, FLT + 6, "mismatch fault");
        chk_rng(cyc - t0, FLT - 4, FLT + 4, "fault delay");
        expect_within(B_KOE, 1'b1, 3, "permit floats on fault");
        expect_within(B_KLS, 1'b0, 3, "hold freed on fault");
        chk({ov[B_KSNK], ov[B_KLS], ov[B_STOE]}, 10'h000, "faulted lines");
        op_key = 1'b0;
        PHASE_INDUCTIVE = 1'b0;
    endtask

    task automatic t_thresh;
        restart();
        home();
        THR_SEL = 1'b1;
        fwd_lvl = 16'h0096;
        rfl_lvl = 16'h0005;
        op_key = 1'b1;
        cycles(KPV + MATCH + 20);
        chk(ov[B_TUNED], 1'b0, "15 W not exceeded");
        fwd_lvl = 16'h0097;
        expect_within(B_TUNED, 1'b1, KPV + MATCH + 10, "above 15 W");
        op_key = 1'b0;
    endtask

    // homing never ends, so only the sequence timer can fault
    task automatic t_timeout;
        int n;
        restart();
        cycles(SEQ - 50);
        RECHANNEL = 1'b1;
        cycles(2);
        RECHANNEL = 1'b0;
        cycles(SEQ - 50);
        chk(ov[B_FLT], 1'b0, "timer cleared by restart");
        expect_within(B_FLT, 1'b1, FLT + 100, "sequence timeout fault");
        wait_bit(B_ST, 1'b0, BLINK + 4, n);
        wait_bit(B_ST, 1'b1, BLINK + 4, n);
        chk_rng(n, BLINK, BLINK, "blink half period");
        chk(ov[B_STOE], 1'b0, "indicator driven on fault");
        restart();
    endtask

    initial begin
        CLK = 1'b0;
        RST_N = 1'b0;
        RECHANNEL = 1'b0;
        ELEMENTS_HOME = 1'b0;
        PHASE_INDUCTIVE = 1'b0;
        THR_SEL = 1'b0;
        op_key = 1'b0;
        fwd_lvl = 16'h0000;
        rfl_lvl = 16'h0000;
        n_fail = 0;
        tests_run = 0;
        cyc = 0;
        t_reset();
        t_tune();
        t_fault();
        t_thresh();
        t_timeout();
        give_verdict();
    end
endmodule
